// >>> hdl/hpc_unit.v
// Purpose: hart counters, event tallies, access gates and stop mask
// Assumes: core presents one csr access per cycle at retire time
// Notes: read data and exception flag answer one cycle after request
// How it works
// - cycle tally counts each core clock
// - instruction tally counts each retired instruction
// - both tallies 64 bits in either width
// - counters undefined at reset, software loadable
// - csr write overrides that cycle's increment
// - 29 event tallies, each with selector
// - selector zero never counts
// - unimplemented tallies read zero with selector
// - narrow mode reads low, upper reads high
// - machine and supervisor gates are 32 bits
// - gate access leaves counters untouched
// - gated lower-mode read raises illegal instruction
// - machine gate opens next lower mode
// - user read needs supervisor gate too
// - hardwired gate zero traps lower-mode reads
// - user counters are read-only mirrors
// - time read served from wall clock input
// - stop mask freezes chosen tallies
// - stop mask does not touch access
// - without mask behave as mask zero
// - wall clock cannot be stopped
// - one cycle tally shared per core
`timescale 1ns/10ps
`default_nettype none
`include "hpc_consts.vh"
module hpc_unit #(
  parameter [31:0] IMPL_EVENTS = 32'hFFFFFFF8,
  parameter [31:0] GATE_WRITABLE = 32'hFFFFFFFF,
  parameter HAS_STOP_MASK = 1,
  parameter HAS_SMODE = 1,
  parameter SEL_WIDTH = 8
) (
  input wire clk,
  input wire reset,
  input wire xlen64,
  input wire [1:0] priv_mode,
  input wire csr_read,
  input wire csr_write,
  input wire [11:0] csr_addr,
  input wire [63:0] csr_wdata,
  input wire instr_retired,
  input wire [31:0] event_lines,
  input wire [63:0] wall_clock,
  output reg [63:0] csr_rdata,
  output reg csr_hit,
  output reg illegal_instr
);
  reg [31:0] mgate;
  reg [31:0] sgate;
  reg [31:0] stop_mask;
  reg [SEL_WIDTH-1:0] sel [3:31];
  wire [63:0] tally [0:31];
  wire [31:0] adv;
  wire [31:0] ld_lo;
  wire [31:0] ld_hi;
  reg [63:0] next_rdata;
  reg next_hit;
  reg next_illegal;
  reg [4:0] idx;
  reg [31:0] eff_stop;

  function gate_ok;
    input [4:0] n;
    input [1:0] mode;
    input [31:0] mg;
    input [31:0] sg;
    begin
      if (mode == `HPC_MODE_M) begin
        gate_ok = 1'b1;
      end else if (mode == `HPC_MODE_S || HAS_SMODE == 0) begin
        gate_ok = mg[n];
      end else begin
        gate_ok = mg[n] & sg[n];
      end
    end
  endfunction

  function [11:0] pick;
    input [11:0] base;
    input [4:0] n;
    begin
      pick = base + {7'h00, n};
    end
  endfunction

  // selector zero picks no event
  function event_fires;
    input [SEL_WIDTH-1:0] choice;
    input [31:0] lines;
    begin
      if (choice == {SEL_WIDTH{1'b0}}) begin
        event_fires = 1'b0;
      end else begin
        event_fires = lines[choice[4:0]];
      end
    end
  endfunction

  // write strobe for one tally half
  function slot_write;
    input [11:0] addr;
    input [11:0] base;
    input [4:0] n;
    input strobe;
    begin
      slot_write = strobe && addr == pick(base, n);
    end
  endfunction

  always @* begin
    eff_stop = (HAS_STOP_MASK != 0) ? stop_mask : 32'h00000000;
    eff_stop[`HPC_BIT_WALL_CLOCK] = 1'b0;
  end

  // cycle tally shared by every hart of the core
  assign adv[`HPC_BIT_CLOCK_TALLY] = ~eff_stop[`HPC_BIT_CLOCK_TALLY];
  assign adv[`HPC_BIT_WALL_CLOCK] = 1'b0;
  assign adv[`HPC_BIT_INSTR_COUNT] = instr_retired & ~eff_stop[`HPC_BIT_INSTR_COUNT];
  assign tally[`HPC_BIT_WALL_CLOCK] = wall_clock;
  assign ld_lo[`HPC_BIT_WALL_CLOCK] = 1'b0;
  assign ld_hi[`HPC_BIT_WALL_CLOCK] = 1'b0;

  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : gen_tally
      localparam [4:0] GI = g;
      if (g != `HPC_BIT_WALL_CLOCK) begin : gen_wr
        // low-word and high-word load strobes
        assign ld_lo[g] = slot_write(csr_addr, `HPC_CSR_MEVT_CNT_BASE, GI, csr_write);
        assign ld_hi[g] = slot_write(csr_addr, `HPC_CSR_MEVT_CNT_UP_BASE, GI, csr_write && !xlen64);
      end
      if (g >= `HPC_FIRST_EVENT) begin : gen_evt
        if (IMPL_EVENTS[g]) begin : gen_real
          assign adv[g] = event_fires(sel[g], event_lines) && !eff_stop[g];
          hpc_tally #(.WIDTH(64)) u_tally (
            .clk(clk),
            .load_low(ld_lo[g]),
            .load_high(ld_hi[g]),
            .load_data(csr_wdata[31:0]),
            .xlen64(xlen64),
            .load_full(csr_wdata),
            .advance(adv[g]),
            .count(tally[g])
          );
        end else begin : gen_zero
          assign adv[g] = 1'b0;
          assign tally[g] = 64'h0000000000000000;
        end
      end else if (g != `HPC_BIT_WALL_CLOCK) begin : gen_fixed
        hpc_tally #(.WIDTH(64)) u_tally (
          .clk(clk),
          .load_low(ld_lo[g]),
          .load_high(ld_hi[g]),
          .load_data(csr_wdata[31:0]),
          .xlen64(xlen64),
          .load_full(csr_wdata),
          .advance(adv[g]),
          .count(tally[g])
        );
      end
    end
  endgenerate

  // csr numbers as 12-bit words
  localparam [11:0] USR_BASE = `HPC_CSR_USR_CNT_BASE;
  localparam [11:0] USR_UP_BASE = `HPC_CSR_USR_CNT_UP_BASE;
  localparam [11:0] MCH_BASE = `HPC_CSR_MEVT_CNT_BASE;
  localparam [11:0] MCH_UP_BASE = `HPC_CSR_MEVT_CNT_UP_BASE;
  localparam [11:0] SEL_BASE = `HPC_CSR_EVT_SEL_BASE;
  localparam [11:0] MGATE_ADDR = `HPC_CSR_MGATE;
  localparam [11:0] SGATE_ADDR = `HPC_CSR_SGATE;
  localparam [11:0] STOP_ADDR = `HPC_CSR_STOP_MASK;
  // wall clock bit cannot be set
  localparam [31:0] STOP_WRITABLE = 32'hFFFFFFFD;

  // address in a 32-entry bank; upper bank only when narrow
  function in_bank;
    input [11:0] addr;
    input [11:0] low_base;
    input [11:0] up_base;
    input narrow;
    begin
      in_bank = (addr[11:5] == low_base[11:5]) || (narrow && addr[11:5] == up_base[11:5]);
    end
  endfunction

  // half or whole counter as a read returns it
  function [63:0] read_half;
    input [63:0] value;
    input upper;
    input wide;
    begin
      if (upper) begin
        read_half = {32'h00000000, value[63:32]};
      end else if (wide) begin
        read_half = value;
      end else begin
        read_half = {32'h00000000, value[31:0]};
      end
    end
  endfunction

  // supervisor gate seen from machine and supervisor mode
  function sgate_visible;
    input [11:0] addr;
    input [1:0] mode;
    begin
      sgate_visible = (HAS_SMODE != 0) && addr == SGATE_ADDR &&
                      (mode == `HPC_MODE_M || mode == `HPC_MODE_S);
    end
  endfunction

  wire in_mach;
  wire wr_mgate;
  wire wr_sgate;
  wire wr_stop;
  wire rd_user;
  wire rd_mach;
  wire rd_sel;
  wire [31:0] read_open;
  wire [63:0] counter_view;

  assign in_mach = priv_mode == `HPC_MODE_M;
  assign wr_mgate = csr_write && csr_addr == MGATE_ADDR;
  assign wr_sgate = csr_write && csr_addr == SGATE_ADDR && HAS_SMODE != 0;
  assign wr_stop = csr_write && csr_addr == STOP_ADDR;
  // bank compares use the top seven address bits
  assign rd_user = in_bank(csr_addr, USR_BASE, USR_UP_BASE, !xlen64);
  assign rd_mach = in_bank(csr_addr, MCH_BASE, MCH_UP_BASE, !xlen64) && csr_addr[4:0] != 5'h01;
  assign rd_sel = csr_addr[11:5] == SEL_BASE[11:5] && csr_addr[4:0] >= 5'h03;
  assign counter_view = read_half(tally[csr_addr[4:0]], csr_addr[7], xlen64);

  // per-counter read permission in the current mode
  genvar r;
  generate
    for (r = 0; r < 32; r = r + 1) begin : gen_open
      localparam [4:0] RI = r;
      assign read_open[r] = gate_ok(RI, priv_mode, mgate, sgate);
    end
  endgenerate

  // gate writes reach no tally
  always @(posedge clk) begin
    if (reset) begin
      mgate <= `HPC_GATE_RESET;
    end else if (wr_mgate) begin
      mgate <= csr_wdata[31:0] & GATE_WRITABLE;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      sgate <= `HPC_GATE_RESET;
    end else if (wr_sgate) begin
      sgate <= csr_wdata[31:0] & GATE_WRITABLE;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      stop_mask <= `HPC_STOP_RESET;
    end else if (wr_stop) begin
      stop_mask <= csr_wdata[31:0] & STOP_WRITABLE;
    end
  end

  // one selector per implemented event tally
  genvar s;
  generate
    for (s = `HPC_FIRST_EVENT; s <= `HPC_LAST_EVENT; s = s + 1) begin : gen_sel
      localparam [4:0] SI = s;
      if (IMPL_EVENTS[s]) begin : gen_sel_real
        always @(posedge clk) begin
          if (reset) begin
            sel[s] <= {SEL_WIDTH{1'b0}};
          end else if (csr_write && csr_addr == pick(SEL_BASE, SI)) begin
            sel[s] <= csr_wdata[SEL_WIDTH-1:0];
          end
        end
      end else begin : gen_sel_zero
        // absent tally keeps a zero selector
        always @(posedge clk) begin
          sel[s] <= {SEL_WIDTH{1'b0}};
        end
      end
    end
  endgenerate

  // read answer, registered below
  always @* begin
    next_rdata = 64'h0000000000000000;
    next_hit = 1'b0;
    next_illegal = 1'b0;
    idx = csr_addr[4:0];
    if (csr_read) begin
      // user mirrors pass the gate check first
      if (rd_user) begin
        next_hit = 1'b1;
        if (!read_open[idx]) begin
          next_illegal = 1'b1;
        end else begin
          next_rdata = counter_view;
        end
      end else if (in_mach && rd_mach) begin
        next_hit = 1'b1;
        next_rdata = counter_view;
      end else if (in_mach && csr_addr == MGATE_ADDR) begin
        next_hit = 1'b1;
        next_rdata = {32'h00000000, mgate};
      end else if (in_mach && csr_addr == STOP_ADDR) begin
        next_hit = 1'b1;
        next_rdata = {32'h00000000, eff_stop};
      end else if (in_mach && rd_sel) begin
        next_hit = 1'b1;
        next_rdata = {{(64-SEL_WIDTH){1'b0}}, sel[idx]};
      end else if (sgate_visible(csr_addr, priv_mode)) begin
        next_hit = 1'b1;
        next_rdata = {32'h00000000, sgate};
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      csr_rdata <= 64'h0000000000000000;
      csr_hit <= 1'b0;
      illegal_instr <= 1'b0;
    end else begin
      csr_rdata <= next_rdata;
      csr_hit <= next_hit;
      illegal_instr <= next_illegal;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/hpc_consts.vh
// Purpose: constants for the hart performance counting unit
// Assumes: csr numbers follow the standard counter csr map
// Notes: counters have no reset value; gates and mask reset to zero
`ifndef HPC_CONSTS_VH
`define HPC_CONSTS_VH
`define HPC_CSR_CYCLE_TALLY 12'hB00
`define HPC_CSR_INSTR_TALLY 12'hB02
`define HPC_CSR_MEVT_CNT_BASE 12'hB00
`define HPC_CSR_CYCLE_TALLY_UP 12'hB80
`define HPC_CSR_MEVT_CNT_UP_BASE 12'hB80
`define HPC_CSR_USR_CNT_BASE 12'hC00
`define HPC_CSR_USR_CNT_UP_BASE 12'hC80
`define HPC_CSR_EVT_SEL_BASE 12'h320
`define HPC_CSR_STOP_MASK 12'h320
`define HPC_CSR_MGATE 12'h306
`define HPC_CSR_SGATE 12'h106
`define HPC_BIT_CLOCK_TALLY 0
`define HPC_BIT_WALL_CLOCK 1
`define HPC_BIT_INSTR_COUNT 2
`define HPC_FIRST_EVENT 3
`define HPC_LAST_EVENT 31
`define HPC_GATE_RESET 32'h00000000
`define HPC_STOP_RESET 32'h00000000
`define HPC_MODE_U 2'h0
`define HPC_MODE_S 2'h1
`define HPC_MODE_M 2'h3
`endif

// >>> hdl/hpc_tally.v
// Purpose: one 64-bit tally with software load
// Assumes: write strobe comes from the csr retire stage
// Notes: a write beats the same-cycle increment
`timescale 1ns/10ps
`default_nettype none
module hpc_tally #(
  parameter WIDTH = 64
) (
  input wire clk,
  input wire load_low,
  input wire load_high,
  input wire [31:0] load_data,
  input wire xlen64,
  input wire [63:0] load_full,
  input wire advance,
  output reg [WIDTH-1:0] count
);
  always @(posedge clk) begin
    // no reset: value arbitrary until written
    if (load_low && xlen64) begin
      count <= load_full[WIDTH-1:0];
    end else if (load_low) begin
      count <= {count[WIDTH-1:32], load_data};
    end else if (load_high) begin
      count <= {load_data, count[31:0]};
    end else if (advance) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// >>> dv/hpc_unit_chk.sv
// Purpose: port checker for hpc_unit
// Assumes: one-cycle answer to reads
// Notes: bound to every hpc_unit
`timescale 1ns/10ps
`default_nettype none
module hpc_unit_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic xlen64,
  input wire logic [1:0] priv_mode,
  input wire logic csr_read,
  input wire logic csr_write,
  input wire logic [11:0] csr_addr,
  input wire logic [63:0] csr_wdata,
  input wire logic [63:0] wall_clock,
  input wire logic [63:0] csr_rdata,
  input wire logic csr_hit,
  input wire logic illegal_instr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_QUIET: assert property (!$past(csr_read) |-> !illegal_instr && csr_rdata == 64'h0) else $error("quiet");
  AST_GATE_WR: assert property (csr_write && csr_addr == 12'h306 |=> !illegal_instr) else $error("gate");
  AST_TRAP: assert property (illegal_instr |->
    csr_hit && $past(priv_mode) != 2'h3 && $past(csr_addr[11:8]) == 4'hC) else $error("trap");
  AST_M_OPEN: assert property (csr_read && priv_mode == 2'h3 |=> !illegal_instr) else $error("m trap");
  AST_HIT: assert property (csr_read && csr_addr[11:5] == 7'h60 |=> csr_hit) else $error("hit");
  AST_TIME: assert property (csr_read && csr_addr == 12'hC01 && xlen64 && priv_mode == 2'h3
    |=> csr_rdata == $past(wall_clock)) else $error("time");
  AST_WR_WINS: assert property (csr_write && csr_addr == 12'hB00 && xlen64 ##1
    csr_read && csr_addr == 12'hB00 && priv_mode == 2'h3 |=> csr_rdata == $past(csr_wdata, 2)) else $error("load");
  AST_HIGH: assert property (csr_read && csr_addr == 12'hC81 && !xlen64 && priv_mode == 2'h3
    |=> csr_rdata[31:0] == $past(wall_clock[63:32])) else $error("high");
endmodule
bind hpc_unit hpc_unit_chk hpc_unit_chk_inst (.clk(clk), .reset(reset), .xlen64(xlen64), .priv_mode(priv_mode),
  .csr_read(csr_read), .csr_write(csr_write), .csr_addr(csr_addr), .csr_wdata(csr_wdata),
  .wall_clock(wall_clock), .csr_rdata(csr_rdata), .csr_hit(csr_hit), .illegal_instr(illegal_instr));
`default_nettype wire

// >>> dv/hpc_core_model.sv
// Purpose: core pipeline stand-in
// Assumes: burst marks cycles that retire and raise all events
// Notes: wall clock free-runs
`timescale 1ns/10ps
`default_nettype none
module hpc_core_model (
  input wire logic clk,
  input wire logic burst,
  output logic instr_retired,
  output logic [31:0] event_lines,
  output var logic [63:0] wall_clock
);
  assign instr_retired = burst;
  assign event_lines = burst ? 32'hFFFFFFFF : 32'h0;
  initial wall_clock = 64'h00000001FFFFFFF0;
  always @(posedge clk) wall_clock <= wall_clock + 64'h1;
endmodule
`default_nettype wire

// >>> dv/hpc_tb.sv
// Purpose: directed bench for hpc_unit
// Assumes: one-cycle read answer
// Notes: reads are spaced two cycles apart
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module testbench;
  logic clk = 0, reset = 1, xlen64 = 1, csr_read = 0, csr_write = 0, burst = 0;
  logic [1:0] priv_mode = 2'h3;
  logic [11:0] csr_addr = 12'h0;
  logic [63:0] csr_wdata = 64'h0, csr_rdata, wall_clock;
  logic csr_hit, illegal_instr, instr_retired;
  logic [31:0] event_lines;
  int fail_count = 0, num_checks = 0, ticks = 0;
  always #5 clk = ~clk;
  hpc_unit hpc_unit_inst (.clk(clk), .reset(reset), .xlen64(xlen64), .priv_mode(priv_mode), .csr_read(csr_read),
    .csr_write(csr_write), .csr_addr(csr_addr), .csr_wdata(csr_wdata), .instr_retired(instr_retired),
    .event_lines(event_lines), .wall_clock(wall_clock), .csr_rdata(csr_rdata), .csr_hit(csr_hit),
    .illegal_instr(illegal_instr));
  hpc_core_model hpc_core_model_inst (.clk(clk), .burst(burst), .instr_retired(instr_retired),
    .event_lines(event_lines), .wall_clock(wall_clock));
  task rq(input logic [1:0] m, input logic w, input logic [11:0] a, input logic [63:0] d);
    @(posedge clk);
    csr_write <= w;
    csr_read <= !w;
    priv_mode <= m;
    csr_addr <= a;
    csr_wdata <= d;
    @(posedge clk);
    csr_write <= 1'b0;
    csr_read <= 1'b0;
    @(negedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [63:0] d);
    rq(2'h3, 1'b1, a, d);
  endtask
  task rd(input logic [1:0] m, input logic [11:0] a);
    rq(m, 1'b0, a, 64'h0);
  endtask
  task t_count;
    @(posedge clk);
    csr_write <= 1'b1;
    csr_addr <= 12'hB00;
    csr_wdata <= 64'hFFFFFFFE;
    @(posedge clk);
    csr_write <= 1'b0;
    csr_read <= 1'b1;
    @(posedge clk);
    csr_read <= 1'b0;
    @(negedge clk);
    `CHK(csr_rdata, 64'hFFFFFFFE)
    rd(2'h3, 12'hB00);
    `CHK(csr_rdata, 64'h100000000)
    wr(12'h320, 64'h3);
    rd(2'h3, 12'h320);
    `CHK(csr_rdata, 64'h1)
    wr(12'hB00, 64'h7);
    rd(2'h3, 12'hB00);
    `CHK(csr_rdata, 64'h7)
    rd(2'h3, 12'hC00);
    `CHK(csr_rdata, 64'h7)
    wr(12'h320, 64'h0);
    $display("count done");
  endtask
  task t_events;
    wr(12'hB02, 64'h10);
    wr(12'hB03, 64'h0);
    wr(12'hB04, 64'h0);
    wr(12'h323, 64'h5);
    @(posedge clk);
    burst <= 1'b1;
    repeat (4) @(posedge clk);
    burst <= 1'b0;
    rd(2'h3, 12'hB02);
    `CHK(csr_rdata, 64'h14)
    rd(2'h3, 12'hB03);
    `CHK(csr_rdata, 64'h4)
    rd(2'h3, 12'hB04);
    `CHK(csr_rdata, 64'h0)
    $display("events done");
  endtask
  task t_gates;
    wr(12'h306, 64'h0);
    rd(2'h1, 12'hC00);
    `CHK(illegal_instr, 1'b1)
    wr(12'h306, 64'h1);
    rd(2'h1, 12'hC00);
    `CHK(illegal_instr, 1'b0)
    rd(2'h1, 12'hC02);
    `CHK(illegal_instr, 1'b1)
    rd(2'h0, 12'hC00);
    `CHK(illegal_instr, 1'b1)
    wr(12'h106, 64'h1);
    wr(12'h320, 64'h1);
    rd(2'h0, 12'hC00);
    `CHK(illegal_instr, 1'b0)
    wr(12'h320, 64'h0);
    rd(2'h3, 12'hC01);
    $display("gates done");
  endtask
  task t_narrow;
    @(posedge clk);
    xlen64 <= 1'b0;
    wr(12'h320, 64'h1);
    wr(12'hB00, 64'hAABBCCDD);
    wr(12'hB80, 64'h11223344);
    rd(2'h3, 12'hB00);
    `CHK(csr_rdata[31:0], 32'hAABBCCDD)
    rd(2'h3, 12'hB80);
    `CHK(csr_rdata[31:0], 32'h11223344)
    rd(2'h3, 12'hC81);
    $display("narrow done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 2000) begin
      fail_count++;
      give_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_count;
    t_events;
    t_gates;
    t_narrow;
    give_verdict;
  end
endmodule
`default_nettype wire
